// ### hdl/adc_seq_consts.vh
// Timing and sizing constants for the conversion sequencer
`ifndef ADC_SEQ_CONSTS_VH
`define ADC_SEQ_CONSTS_VH

// Cycle counts at the 10 ns system clock
`define CONV_INT_CYC 9'h0f0
`define CONV_EXT_CYC 9'h140
`define EOC_LOW_CYC 9'h00c
`define EXT_EDGES_PER_CONV 5'h10
`define NUM_CH 4
`define RES_W 14
`define CNT_W 9
`define RESULT_RST 14'h0000
`define RD_PTR_RST 2'h0

`endif

// ### hdl/adc_sequence_read_timing.v
// Conversion sequencer and parallel read port of a four-channel converter
`timescale 1ns/1ps
`include "adc_seq_consts.vh"

module adc_sequence_read_timing (
	// Clock and reset
	input wire clock_i,
	input wire rst_i,
	// Conversion control pins
	input wire conversion_start_n_i,
	input wire low_power_request_n_i,
	input wire ext_clk_sel_i,
	input wire ext_clk_i,
	input wire [3:0] channel_sel_i,
	// Held samples from the track/hold front end
	input wire [55:0] sample_i,
	// Read port pins
	input wire cs_n_i,
	input wire rd_n_i,
	// Status and data pins
	output reg busy_o,
	output reg eoc_n_o,
	output reg first_result_flag_o,
	output reg [13:0] data_o,
	output reg data_oe_n_o
);

	localparam [`CNT_W-1:0] INT_CONV_CYC = `CONV_INT_CYC;
	localparam [`CNT_W-1:0] EXT_CONV_CYC = `CONV_EXT_CYC;
	localparam [`CNT_W-1:0] EOC_CYC = `EOC_LOW_CYC;
	localparam [`CNT_W-1:0] ONE_CYC = {{(`CNT_W-1){1'b0}}, 1'b1};

	localparam [2:0] ST_IDLE = 3'h1;
	localparam [2:0] ST_CONV = 3'h2;
	localparam [2:0] ST_EOC = 3'h4;

	// Next selected channel at or after index from; bit 2 set means none
	function [2:0] next_sel;
		input [3:0] mask;
		input [2:0] from;
		integer k;
		begin
			next_sel = 3'h4;
			for (k = 3; k >= 0; k = k - 1) begin
				if (mask[k] && (k >= from))
					next_sel = k[2:0];
			end
		end
	endfunction

	// Pin synchronisers, two flops each, plus edge history of stage two
	reg [5:0] meta_r;
	reg [5:0] sync_r;
	reg cst_prev_r;
	reg eck_prev_r;
	reg rd_prev_r;
	wire cst_s = sync_r[0];
	wire lpr_n_s = sync_r[1];
	wire esel_s = sync_r[2];
	wire eck_s = sync_r[3];
	wire cs_n_s = sync_r[4];
	wire rd_n_s = sync_r[5];
	reg [3:0] chsel_m_r;
	reg [3:0] chsel_s_r;

	always @(posedge clock_i) begin
		if (rst_i) begin
			// Idle pin levels, so no false edge follows reset
			meta_r <= 6'h33;
			sync_r <= 6'h33;
			chsel_m_r <= 4'h0;
			chsel_s_r <= 4'h0;
			cst_prev_r <= 1'b1;
			eck_prev_r <= 1'b0;
			rd_prev_r <= 1'b1;
		end else begin
			meta_r <= {rd_n_i, cs_n_i, ext_clk_i, ext_clk_sel_i,
				low_power_request_n_i, conversion_start_n_i};
			sync_r <= meta_r;
			chsel_m_r <= channel_sel_i;
			chsel_s_r <= chsel_m_r;
			cst_prev_r <= cst_s;
			eck_prev_r <= eck_s;
			rd_prev_r <= rd_n_s;
		end
	end

	wire cst_fall = cst_prev_r & ~cst_s;
	wire cst_rise = ~cst_prev_r & cst_s;
	wire eck_rise = ~eck_prev_r & eck_s;
	wire rd_fall = rd_prev_r & ~rd_n_s & ~cs_n_s;
	wire rd_rise = ~rd_prev_r & rd_n_s;

	// Sequencer state
	reg [2:0] state_r;
	reg [3:0] mask_r;
	reg ext_mode_r;
	reg [2:0] ch_r;
	reg [`CNT_W-1:0] cnt_r;
	reg [4:0] edges_r;
	reg [55:0] held_r;
	reg [13:0] result_r [0:3];
	reg [1:0] n_res_r;
	reg [1:0] wr_ptr_r;
	reg [1:0] rd_ptr_r;
	reg reading_r;

	wire [2:0] first_ch = next_sel(chsel_s_r, 3'h0);
	wire [2:0] follow_ch = next_sel(mask_r, ch_r + 3'h1);
	// Counter starts at zero: conversion plus EOC fills the slot exactly
	wire slot_ext_done = (edges_r == `EXT_EDGES_PER_CONV) ||
		(cnt_r >= EXT_CONV_CYC - EOC_CYC - ONE_CYC);
	wire slot_int_done = (cnt_r >= INT_CONV_CYC - EOC_CYC - ONE_CYC);
	wire conv_done = ext_mode_r ? slot_ext_done : slot_int_done;
	wire [1:0] rd_ptr_inc = rd_ptr_r + 2'h1;
	wire [1:0] rd_ptr_next = (rd_ptr_r == n_res_r) ? 2'h0 : rd_ptr_inc;

	integer i;

	always @(posedge clock_i) begin
		if (rst_i) begin
			state_r <= ST_IDLE;
			mask_r <= 4'h0;
			ext_mode_r <= 1'b0;
			ch_r <= 3'h0;
			cnt_r <= {`CNT_W{1'b0}};
			edges_r <= 5'h00;
			held_r <= 56'h0;
			n_res_r <= 2'h0;
			wr_ptr_r <= 2'h0;
			busy_o <= 1'b0;
			eoc_n_o <= 1'b1;
			for (i = 0; i < `NUM_CH; i = i + 1) begin
				result_r[i] <= `RESULT_RST;
			end
		end else begin
			// Falling start edge in idle places every track/hold into hold
			if (cst_fall && (state_r == ST_IDLE))
				held_r <= sample_i;
			case (state_r)
			ST_IDLE: begin
				eoc_n_o <= 1'b1;
				// Starts during standby are dropped; wake-up is host timed
				if (cst_rise && lpr_n_s && !first_ch[2]) begin
					busy_o <= 1'b1;
					mask_r <= chsel_s_r;
					ext_mode_r <= esel_s;
					ch_r <= first_ch;
					cnt_r <= {`CNT_W{1'b0}};
					edges_r <= 5'h00;
					wr_ptr_r <= 2'h0;
					n_res_r <= 2'h0;
					state_r <= ST_CONV;
				end
			end
			ST_CONV: begin
				cnt_r <= cnt_r + {{(`CNT_W-1){1'b0}}, 1'b1};
				if (eck_rise)
					edges_r <= edges_r + 5'h01;
				// Cycle cap keeps a slow external clock within bound
				if (conv_done) begin
					result_r[wr_ptr_r] <= held_r[ch_r[1:0]*14 +: 14];
					n_res_r <= wr_ptr_r;
					wr_ptr_r <= wr_ptr_r + 2'h1;
					eoc_n_o <= 1'b0;
					cnt_r <= {`CNT_W{1'b0}};
					state_r <= ST_EOC;
				end
			end
			ST_EOC: begin
				cnt_r <= cnt_r + {{(`CNT_W-1){1'b0}}, 1'b1};
				if (cnt_r == EOC_CYC - {{(`CNT_W-1){1'b0}}, 1'b1}) begin
					eoc_n_o <= 1'b1;
					cnt_r <= {`CNT_W{1'b0}};
					edges_r <= 5'h00;
					if (follow_ch[2]) begin
						busy_o <= 1'b0;
						state_r <= ST_IDLE;
					end else begin
						ch_r <= follow_ch;
						state_r <= ST_CONV;
					end
				end
			end
			default: begin
				state_r <= ST_IDLE;
				busy_o <= 1'b0;
				eoc_n_o <= 1'b1;
			end
			endcase
		end
	end

	// Read port: n_res_r holds count minus one, so wrap after the last result
	always @(posedge clock_i) begin
		if (rst_i) begin
			rd_ptr_r <= `RD_PTR_RST;
			reading_r <= 1'b0;
			data_o <= `RESULT_RST;
			data_oe_n_o <= 1'b1;
			first_result_flag_o <= 1'b0;
		end else begin
			if (state_r == ST_CONV && conv_done) begin
				// Same edge as end-of-conversion falling
				first_result_flag_o <= 1'b0;
			end else if (rd_rise && reading_r) begin
				first_result_flag_o <= (rd_ptr_next == 2'h0);
			end
			// A read that ends on a later EOC edge must still advance
			if (state_r == ST_CONV && conv_done && (wr_ptr_r == 2'h0))
				rd_ptr_r <= `RD_PTR_RST;
			else if (rd_rise && reading_r)
				rd_ptr_r <= rd_ptr_next;
			if (rd_fall) begin
				reading_r <= 1'b1;
				data_o <= result_r[rd_ptr_r];
				data_oe_n_o <= 1'b0;
			end else if (rd_n_s || cs_n_s) begin
				data_oe_n_o <= 1'b1;
				if (rd_rise)
					reading_r <= 1'b0;
			end
		end
	end

endmodule

// ### test/adc_seq_checker.sv
// Pin-level assertions for the sequencer
`timescale 1ns/1ps
module adc_seq_checker(
	input wire clock_i, rst_i, conversion_start_n_i,
	input wire low_power_request_n_i, ext_clk_sel_i, rd_n_i,
	input wire busy_o, eoc_n_o, first_result_flag_o, data_oe_n_o);
	reg [10:0] conv_r;
	always @(posedge clock_i)
		conv_r <= (rst_i || !busy_o || !eoc_n_o) ? 11'h0 : conv_r + 11'h1;
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	conv_time_a:
	assert property (conv_r <= (ext_clk_sel_i ? 11'h140 : 11'h0f0))
		else $error("channel conversion too long");
	busy_rise_a:
	assert property ($rose(conversion_start_n_i) && !busy_o &&
		low_power_request_n_i |-> ##[1:7] busy_o) else $error("busy late");
	eoc_width_a:
	assert property ($fell(eoc_n_o) |-> !eoc_n_o[*8] ##1 !eoc_n_o[*4]
		##[1:7] eoc_n_o) else $error("end pulse width");
	eoc_busy_a:
	assert property (!eoc_n_o |-> busy_o) else $error("end pulse idle");
	flag_eoc_a:
	assert property ($fell(eoc_n_o) |-> !first_result_flag_o)
		else $error("flag not low");
	flag_src_a:
	assert property ($changed(first_result_flag_o) |->
		$rose(data_oe_n_o) || $fell(eoc_n_o)) else $error("flag moved");
	rd_end_a:
	assert property ($rose(rd_n_i) && !data_oe_n_o |-> ##[1:7] data_oe_n_o)
		else $error("read not ended");
	standby_a:
	assert property (!$past(low_power_request_n_i, 2) && !busy_o |=> !busy_o)
		else $error("start in standby");
endmodule
bind adc_sequence_read_timing adc_seq_checker chk(.clock_i(clock_i),
	.rst_i(rst_i), .conversion_start_n_i(conversion_start_n_i),
	.low_power_request_n_i(low_power_request_n_i),
	.ext_clk_sel_i(ext_clk_sel_i), .rd_n_i(rd_n_i), .busy_o(busy_o),
	.eoc_n_o(eoc_n_o), .first_result_flag_o(first_result_flag_o),
	.data_oe_n_o(data_oe_n_o));

// ### test/host_model.sv
// Host side: start pulses, external clock and strobed reads
`timescale 1ns/1ps
module host_model(
	input wire clock_i, busy_o, first_result_flag_o, data_oe_n_o,
	input wire [13:0] data_o,
	output reg conversion_start_n_i = 1'b1, low_power_request_n_i = 1'b1,
	output reg ext_clk_i = 1'b0, cs_n_i = 1'b1, rd_n_i = 1'b1);
	reg run_clk = 1'b0;
	// Odd half period keeps it off the system clock phase
	// Parked low outside frames
	always #100.3 ext_clk_i = run_clk ? !ext_clk_i : 1'b0;
	task convert(input x, output integer n);
		begin
			repeat (40) @(negedge clock_i);
			conversion_start_n_i = 1'b0;
			repeat (25) @(negedge clock_i);
			run_clk = x;
			conversion_start_n_i = 1'b1;
			n = 0;
			repeat (6) @(negedge clock_i) n = n + busy_o;
			while (busy_o === 1'b1 && n < 2000) @(negedge clock_i) n = n + busy_o;
			run_clk = 1'b0;
		end
	endtask
	task rd(output [13:0] d, output f);
		begin
			@(negedge clock_i);
			cs_n_i = 1'b0;
			rd_n_i = 1'b0;
			repeat (5) @(negedge clock_i);
			d = data_oe_n_o === 1'b0 ? data_o : 14'hx;
			rd_n_i = 1'b1;
			cs_n_i = 1'b1;
			repeat (5) @(negedge clock_i);
			f = first_result_flag_o;
		end
	endtask
	task sleep(output b);
		begin
			@(negedge clock_i);
			low_power_request_n_i = 1'b0;
			repeat (10) @(negedge clock_i);
			conversion_start_n_i = 1'b0;
			repeat (10) @(negedge clock_i);
			conversion_start_n_i = 1'b1;
			b = 1'b0;
			repeat (20) @(negedge clock_i) b = b | busy_o;
			low_power_request_n_i = 1'b1;
			repeat (100) @(negedge clock_i);
		end
	endtask
endmodule

// ### test/tb_adc_sequence_read_timing.sv
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module tb_adc_sequence_read_timing;
	reg clock_i = 1'b0, rst_i = 1'b1, ext_clk_sel_i = 1'b0, f, b;
	reg [3:0] channel_sel_i = 4'hf;
	reg [55:0] sample_i = {14'h2a5c, 14'h1234, 14'h0f0e, 14'h3bcd};
	reg [13:0] d;
	wire cs, rdn, st, lp, ec, busy_o, eoc_n_o, flag, oe_n;
	wire [13:0] data_o;
	integer n_mismatch = 0, num_checks = 0, n, k;
	always #5 clock_i = !clock_i;
	adc_sequence_read_timing DUT(.clock_i(clock_i), .rst_i(rst_i),
		.conversion_start_n_i(st), .low_power_request_n_i(lp),
		.ext_clk_sel_i(ext_clk_sel_i), .ext_clk_i(ec),
		.channel_sel_i(channel_sel_i), .sample_i(sample_i), .cs_n_i(cs),
		.rd_n_i(rdn), .busy_o(busy_o), .eoc_n_o(eoc_n_o),
		.first_result_flag_o(flag), .data_o(data_o), .data_oe_n_o(oe_n));
	host_model host(.clock_i(clock_i), .busy_o(busy_o),
		.first_result_flag_o(flag), .data_oe_n_o(oe_n), .data_o(data_o),
		.conversion_start_n_i(st), .low_power_request_n_i(lp),
		.ext_clk_i(ec), .cs_n_i(cs), .rd_n_i(rdn));
	task check(input ok, input [95:0] m);
		begin
			num_checks = num_checks + 1;
			if (ok !== 1'b1) begin
				n_mismatch = n_mismatch + 1;
				$display("[ERR] %0t %0s", $time, m);
			end
		end
	endtask
	task seq(input [3:0] m, input x);
		begin
			channel_sel_i = m;
			ext_clk_sel_i = x;
			host.convert(x, n);
			check(n > 0 && n <= (x ? 320 : 240) * $countones(m), "busy");
			check(flag === 1'b0, "flag");
			for (k = 0; k < 4; k = k + 1) if (m[k]) begin
				host.rd(d, f);
				check(d === sample_i[14*k +: 14], "data");
				check(f === ((m >> (k + 1)) == 4'h0), "first flag");
			end
			check(f === 1'b1, "wrap flag");
			$display("seq %h ext %0d done", m, x);
		end
	endtask
	task test_four_internal;
		seq(4'hf, 1'b0);
	endtask
	task test_pair_external;
		seq(4'h5, 1'b1);
	endtask
	task test_single_internal;
		seq(4'h8, 1'b0);
	endtask
	task test_standby_wake;
		begin
			host.sleep(b);
			check(b === 1'b0, "standby");
			$display("standby done");
			seq(4'h6, 1'b1);
		end
	endtask
	task give_verdict;
		begin
			$display("checks %0d mismatches %0d", num_checks, n_mismatch);
			if (n_mismatch == 0 && num_checks > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask
	initial begin
		repeat (3) @(negedge clock_i);
		rst_i = 1'b0;
		repeat (3) @(negedge clock_i);
		test_four_internal;
		test_pair_external;
		test_single_internal;
		test_standby_wake;
		give_verdict;
	end
	initial begin
		#400000;
		check(1'b0, "timeout");
		give_verdict;
	end
endmodule
